// File: eph_top.sv
/*
  Host end of a 1284 parallel port: EPP cycles with retry, ECP forward
  and reverse transfers through a small data FIFO.
  Assumes the peripheral drives busy, ack_n and data synchronous to the
  clock, and the access port repeats a retried request unchanged.
*/
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Slow EPP cycle ends access with retry.
// - Repeated access completes without a new cycle.
// - Address write releases strobe four after busy.
// - Address write ends two after busy low.
// - Address read releases three after busy; ends low.
// - Filters add two cycles to responses.
// - FIFO write answers at once.
// - FIFO write leaves running forward transfer alone.
// - Forward: release two after busy, end two.
// - Reverse: assert auto-feed three after ack low.
// - Reverse: release auto-feed two after ack high.
// - Reverse data stored as auto-feed releases; a full FIFO drops it.
// - FIFO read never starts or disturbs reverse.
// - Data write releases strobe three after busy.
module eph_top
  import eph_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Access port
  input wire eph_pkg::eph_req_t req_in,
  output var eph_pkg::eph_ans_t ans_out,
  // Mode
  input wire logic filter_en_in,
  input wire logic ecp_reverse_in,
  // Parallel port
  input wire logic busy_in,
  input wire logic ack_n_in,
  input wire logic [eph_pkg::EPH_DW-1:0] pd_in,
  output var eph_pkg::eph_pins_t pins_out
);
  import eph_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    eph_state_t st;
    logic [2:0] cnt;
    logic [EPH_CNT_W-1:0] wait_cnt;
    logic busy_s1;
    logic busy_s2;
    logic ack_s1;
    logic ack_s2;
    logic busy_f1;
    logic busy_f2;
    logic ack_f1;
    logic ack_f2;
    logic pend_act;
    logic pend_retried;
    logic pend_done;
    eph_req_kind_t pend_kind;
    logic [EPH_DW-1:0] epp_data;
    logic [EPH_FIFO_DEPTH-1:0][EPH_DW-1:0] mem;
    logic [EPH_PTR_W-1:0] rd_ptr;
    logic [EPH_PTR_W-1:0] wr_ptr;
    logic [EPH_PTR_W:0] level;
    eph_ans_t ans;
    eph_pins_t pins;
  } eph_regs_t;

  eph_regs_t r;
  eph_regs_t next_r;
  logic busy_smp;
  logic ack_low_smp;
  logic do_push;
  logic do_pop;
  logic [EPH_DW-1:0] push_data;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [EPH_PTR_W-1:0] ptr_inc(
    input logic [EPH_PTR_W-1:0] p
  );
    ptr_inc = p + 4'h1;
  endfunction : ptr_inc

  // Counter preload: the action lands this many cycles after the sample
  function automatic logic [2:0] dly_load(input logic [2:0] d);
    dly_load = d - 3'h2;
  endfunction : dly_load

  function automatic logic [2:0] epp_rel_dly(input eph_req_kind_t k);
    case (k)
      EPH_REQ_EPP_ADDR_WR: epp_rel_dly = EPH_DLY_ADDR_WR_REL;
      EPH_REQ_EPP_ADDR_RD: epp_rel_dly = EPH_DLY_ADDR_RD_REL;
      default: epp_rel_dly = EPH_DLY_DATA_REL;
    endcase
  endfunction : epp_rel_dly

  function automatic logic is_epp_wr(input eph_req_kind_t k);
    is_epp_wr = (k == EPH_REQ_EPP_DATA_WR) || (k == EPH_REQ_EPP_ADDR_WR);
  endfunction : is_epp_wr

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    do_push = 1'b0;
    do_pop = 1'b0;
    push_data = req_in.wdata;
    next_r.ans.done = 1'b0;
    next_r.ans.retry = 1'b0;
    // Two-stage synchronisers
    next_r.busy_s1 = busy_in;
    next_r.busy_s2 = r.busy_s1;
    next_r.ack_s1 = ~ack_n_in;
    next_r.ack_s2 = r.ack_s1;
    // Filtered copy trails the plain path by exactly two cycles
    next_r.busy_f1 = r.busy_s2;
    next_r.busy_f2 = r.busy_f1;
    next_r.ack_f1 = r.ack_s2;
    next_r.ack_f2 = r.ack_f1;
    busy_smp = filter_en_in ? r.busy_f2 : r.busy_s2;
    ack_low_smp = filter_en_in ? r.ack_f2 : r.ack_s2;

    // Access port
    if (req_in.valid)
    begin
      case (req_in.kind)
        EPH_REQ_FIFO_WR:
        begin
          // Answered now; the pin machine is never touched here
          if (r.level != EPH_FIFO_DEPTH[EPH_PTR_W:0] && !ecp_reverse_in)
          begin
            do_push = 1'b1;
            next_r.ans.done = 1'b1;
          end
          else
          begin
            next_r.ans.retry = 1'b1;
          end
        end
        EPH_REQ_FIFO_RD:
        begin
          // Pops only; reverse transfers run on ack alone
          if (r.level != '0)
          begin
            do_pop = 1'b1;
            next_r.ans.rdata = r.mem[r.rd_ptr];
            next_r.ans.done = 1'b1;
          end
          else
          begin
            next_r.ans.retry = 1'b1;
          end
        end
        default:
        begin
          if (r.pend_done && req_in.kind == r.pend_kind)
          begin
            next_r.ans.done = 1'b1;
            next_r.ans.rdata = r.epp_data;
            next_r.pend_done = 1'b0;
          end
          else if (r.st == EPH_ST_IDLE && !r.pend_retried && !r.pend_done
                   && !ecp_reverse_in)
          begin
            next_r.pend_act = 1'b1;
            next_r.pend_kind = req_in.kind;
            next_r.wait_cnt = '0;
            next_r.st = EPH_ST_EPP_WAIT_HI;
            next_r.pins.pd_oe = is_epp_wr(req_in.kind);
            if (is_epp_wr(req_in.kind))
            begin
              next_r.pins.pd = req_in.wdata;
            end
            if (req_in.kind[1])
            begin
              next_r.pins.slin_n = 1'b0;
            end
            else
            begin
              next_r.pins.afd_n = 1'b0;
            end
          end
          else
          begin
            next_r.ans.retry = 1'b1;
          end
        end
      endcase
    end

    // Sixteen-cycle limit on a first attempt
    if (r.pend_act)
    begin
      if (r.wait_cnt == EPH_RETRY_LIMIT)
      begin
        next_r.ans.retry = 1'b1;
        next_r.pend_act = 1'b0;
        next_r.pend_retried = 1'b1;
      end
      else
      begin
        next_r.wait_cnt = r.wait_cnt + 5'h01;
      end
    end

    // Pin machine
    case (r.st)
      EPH_ST_IDLE:
      begin
        if (ecp_reverse_in && ack_low_smp)
        begin
          next_r.pins.pd_oe = 1'b0;
          next_r.cnt = dly_load(EPH_DLY_REV_ASSERT);
          next_r.st = EPH_ST_REV_CNT_ASSERT;
        end
        // An EPP cycle launched this cycle keeps the pins to itself
        else if (!ecp_reverse_in && r.level != '0 && !do_pop
                 && next_r.st == EPH_ST_IDLE)
        begin
          next_r.pins.pd = r.mem[r.rd_ptr];
          next_r.pins.pd_oe = 1'b1;
          next_r.pins.stb_n = 1'b0;
          do_pop = 1'b1;
          next_r.st = EPH_ST_FWD_WAIT_HI;
        end
      end
      EPH_ST_EPP_WAIT_HI:
      begin
        if (busy_smp)
        begin
          next_r.cnt = dly_load(epp_rel_dly(r.pend_kind));
          next_r.st = EPH_ST_EPP_CNT_REL;
        end
      end
      EPH_ST_EPP_CNT_REL:
      begin
        if (r.cnt == 3'h0)
        begin
          next_r.pins.slin_n = EPH_STROBE_IDLE;
          next_r.pins.afd_n = EPH_STROBE_IDLE;
          if (!is_epp_wr(r.pend_kind))
          begin
            next_r.epp_data = pd_in;
          end
          next_r.st = EPH_ST_EPP_WAIT_LO;
        end
        else
        begin
          next_r.cnt = r.cnt - 3'h1;
        end
      end
      EPH_ST_EPP_WAIT_LO:
      begin
        if (!busy_smp)
        begin
          if (is_epp_wr(r.pend_kind))
          begin
            next_r.cnt = dly_load(EPH_DLY_WR_END);
            next_r.st = EPH_ST_EPP_CNT_END;
          end
          else
          begin
            next_r.st = EPH_ST_IDLE;
          end
        end
      end
      EPH_ST_EPP_CNT_END:
      begin
        if (r.cnt == 3'h0)
        begin
          // Data lines stay driven after a write
          next_r.pins.pd_oe = 1'b1;
          next_r.st = EPH_ST_IDLE;
        end
        else
        begin
          next_r.cnt = r.cnt - 3'h1;
        end
      end
      EPH_ST_FWD_WAIT_HI:
      begin
        if (busy_smp)
        begin
          next_r.cnt = dly_load(EPH_DLY_FWD_REL);
          next_r.st = EPH_ST_FWD_CNT_REL;
        end
      end
      EPH_ST_FWD_CNT_REL:
      begin
        if (r.cnt == 3'h0)
        begin
          next_r.pins.stb_n = EPH_STROBE_IDLE;
          next_r.st = EPH_ST_FWD_WAIT_LO;
        end
        else
        begin
          next_r.cnt = r.cnt - 3'h1;
        end
      end
      EPH_ST_FWD_WAIT_LO:
      begin
        if (!busy_smp)
        begin
          next_r.cnt = dly_load(EPH_DLY_FWD_END);
          next_r.st = EPH_ST_FWD_CNT_END;
        end
      end
      EPH_ST_FWD_CNT_END:
      begin
        if (r.cnt == 3'h0)
        begin
          next_r.st = EPH_ST_IDLE;
        end
        else
        begin
          next_r.cnt = r.cnt - 3'h1;
        end
      end
      EPH_ST_REV_CNT_ASSERT:
      begin
        if (r.cnt == 3'h0)
        begin
          next_r.pins.afd_n = 1'b0;
          next_r.epp_data = pd_in;
          next_r.st = EPH_ST_REV_WAIT_HI;
        end
        else
        begin
          next_r.cnt = r.cnt - 3'h1;
        end
      end
      EPH_ST_REV_WAIT_HI:
      begin
        if (!ack_low_smp)
        begin
          next_r.cnt = dly_load(EPH_DLY_REV_REL);
          next_r.st = EPH_ST_REV_CNT_REL;
        end
      end
      EPH_ST_REV_CNT_REL:
      begin
        if (r.cnt == 3'h0)
        begin
          next_r.pins.afd_n = EPH_STROBE_IDLE;
          // A full FIFO drops the byte rather than stall the peripheral
          if (r.level != EPH_FIFO_DEPTH[EPH_PTR_W:0] && !do_push)
          begin
            do_push = 1'b1;
            push_data = r.epp_data;
          end
          next_r.st = EPH_ST_IDLE;
        end
        else
        begin
          next_r.cnt = r.cnt - 3'h1;
        end
      end
      default:
      begin
        next_r.st = EPH_ST_IDLE;
      end
    endcase

    // Finished EPP cycle answers now or waits for the repeat
    if (r.st != EPH_ST_IDLE && next_r.st == EPH_ST_IDLE
        && (r.pend_act || r.pend_retried) && !ecp_reverse_in
        && r.st <= EPH_ST_EPP_CNT_END)
    begin
      next_r.pend_retried = 1'b0;
      if (r.pend_act && !next_r.ans.retry)
      begin
        next_r.pend_act = 1'b0;
        next_r.ans.done = 1'b1;
        next_r.ans.rdata = is_epp_wr(r.pend_kind) ? r.epp_data :
                           next_r.epp_data;
      end
      else
      begin
        next_r.pend_act = 1'b0;
        next_r.pend_done = 1'b1;
      end
    end

    // FIFO bookkeeping
    if (do_push)
    begin
      next_r.mem[r.wr_ptr] = push_data;
      next_r.wr_ptr = ptr_inc(r.wr_ptr);
    end
    if (do_pop)
    begin
      next_r.rd_ptr = ptr_inc(r.rd_ptr);
    end
    next_r.level = r.level + {4'h0, do_push} - {4'h0, do_pop};
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      r <= '0;
      r.st <= EPH_ST_IDLE;
      r.pins.stb_n <= EPH_STROBE_IDLE;
      r.pins.afd_n <= EPH_STROBE_IDLE;
      r.pins.slin_n <= EPH_STROBE_IDLE;
      r.pins.pd <= EPH_DATA_RST;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign ans_out = r.ans;
  assign pins_out = r.pins;
endmodule : eph_top
`default_nettype wire

// File: eph_pkg.sv
/*
  Constants and carrier types for the parallel port host handshake.
  Assumes one 200 MHz clock; peripheral inputs arrive synchronous to it.
*/
`default_nettype none
package eph_pkg;
  // ---------------------------------------------------------------
  // Widths and depths
  // ---------------------------------------------------------------
  localparam int EPH_DW = 8;
  localparam int EPH_FIFO_DEPTH = 16;
  localparam int EPH_PTR_W = 4;
  localparam int EPH_CNT_W = 5;
  // ---------------------------------------------------------------
  // Handshake timing, cycles after an input sample
  // ---------------------------------------------------------------
  localparam logic [2:0] EPH_DLY_DATA_REL = 3'h3;
  localparam logic [2:0] EPH_DLY_ADDR_WR_REL = 3'h4;
  localparam logic [2:0] EPH_DLY_ADDR_RD_REL = 3'h3;
  localparam logic [2:0] EPH_DLY_WR_END = 3'h2;
  localparam logic [2:0] EPH_DLY_FWD_REL = 3'h2;
  localparam logic [2:0] EPH_DLY_FWD_END = 3'h2;
  localparam logic [2:0] EPH_DLY_REV_ASSERT = 3'h3;
  localparam logic [2:0] EPH_DLY_REV_REL = 3'h2;
  localparam logic [EPH_CNT_W-1:0] EPH_RETRY_LIMIT = 5'h0f;
  // ---------------------------------------------------------------
  // Reset values of the port pins
  // ---------------------------------------------------------------
  localparam logic EPH_STROBE_IDLE = 1'b1;
  localparam logic [EPH_DW-1:0] EPH_DATA_RST = 8'h00;
  // ---------------------------------------------------------------
  // Request kinds and states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    EPH_REQ_EPP_DATA_WR = 3'b000,
    EPH_REQ_EPP_DATA_RD = 3'b001,
    EPH_REQ_EPP_ADDR_WR = 3'b010,
    EPH_REQ_EPP_ADDR_RD = 3'b011,
    EPH_REQ_FIFO_WR = 3'b100,
    EPH_REQ_FIFO_RD = 3'b101
  } eph_req_kind_t;
  typedef enum logic [3:0] {
    EPH_ST_IDLE = 4'b0000,
    EPH_ST_EPP_WAIT_HI = 4'b0001,
    EPH_ST_EPP_CNT_REL = 4'b0010,
    EPH_ST_EPP_WAIT_LO = 4'b0011,
    EPH_ST_EPP_CNT_END = 4'b0100,
    EPH_ST_FWD_WAIT_HI = 4'b0101,
    EPH_ST_FWD_CNT_REL = 4'b0110,
    EPH_ST_FWD_WAIT_LO = 4'b0111,
    EPH_ST_FWD_CNT_END = 4'b1000,
    EPH_ST_REV_CNT_ASSERT = 4'b1001,
    EPH_ST_REV_WAIT_HI = 4'b1010,
    EPH_ST_REV_CNT_REL = 4'b1011
  } eph_state_t;
  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    eph_req_kind_t kind;
    logic [EPH_DW-1:0] wdata;
  } eph_req_t;
  typedef struct packed {
    logic done;
    logic retry;
    logic [EPH_DW-1:0] rdata;
  } eph_ans_t;
  typedef struct packed {
    logic stb_n;
    logic afd_n;
    logic slin_n;
    logic [EPH_DW-1:0] pd;
    logic pd_oe;
  } eph_pins_t;
endpackage : eph_pkg
`default_nettype wire

// File: eph_asserts.sv
/*
  Checker for the parallel port host handshake, bound to eph_top.
  Assumes busy and ack_n change just after a clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module eph_asserts
  import eph_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire eph_pkg::eph_req_t req_in,
  input wire eph_pkg::eph_ans_t ans_out,
  input wire logic filter_en_in,
  input wire logic ecp_reverse_in,
  input wire logic busy_in,
  input wire logic ack_n_in,
  input wire logic [eph_pkg::EPH_DW-1:0] pd_in,
  input wire eph_pkg::eph_pins_t pins_out
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  // Windows allow for the two synchroniser stages
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  logic epp_rq;
  logic plain;
  assign epp_rq = req_in.valid && !req_in.kind[2];
  assign plain = !filter_en_in && !ecp_reverse_in;
  a_epp_answer_bound: assert property (epp_rq |-> ##[1:17]
    (ans_out.done || ans_out.retry)) else $error("epp access unanswered");
  a_fifo_wr_now: assert property (req_in.valid &&
    req_in.kind == EPH_REQ_FIFO_WR |=> ans_out.done || ans_out.retry)
    else $error("fifo write not answered next cycle");
  a_answer_excl: assert property (!(ans_out.done && ans_out.retry))
    else $error("done and retry together");
  a_addr_wr_rel: assert property (plain && pins_out.pd_oe &&
    !pins_out.slin_n && $rose(busy_in) |-> ##[5:8] $rose(pins_out.slin_n))
    else $error("address write release late");
  a_data_wr_rel: assert property (plain && pins_out.pd_oe &&
    !pins_out.afd_n && $rose(busy_in) |-> ##[4:7] $rose(pins_out.afd_n))
    else $error("data write release late");
  a_addr_rd_rel: assert property (plain && !pins_out.pd_oe &&
    !pins_out.slin_n && $rose(busy_in) |-> ##[4:7] $rose(pins_out.slin_n))
    else $error("address read release late");
  a_filt_addr_rel: assert property (filter_en_in && pins_out.pd_oe &&
    !pins_out.slin_n && $rose(busy_in) |-> ##[7:10] $rose(pins_out.slin_n))
    else $error("filtered release late");
  a_fwd_rel: assert property (plain && !pins_out.stb_n &&
    $rose(busy_in) |-> ##[3:6] $rose(pins_out.stb_n))
    else $error("forward strobe release late");
  a_rev_afd_on: assert property (ecp_reverse_in && !filter_en_in &&
    $fell(ack_n_in) |-> ##[4:7] $fell(pins_out.afd_n))
    else $error("reverse auto-feed late");
  a_rev_afd_off: assert property (ecp_reverse_in && !filter_en_in &&
    $rose(ack_n_in) |-> ##[3:6] $rose(pins_out.afd_n))
    else $error("reverse auto-feed release late");
  c_retry: cover property (ans_out.retry);
  c_filtered: cover property (filter_en_in && $rose(busy_in));
  c_reverse: cover property (ecp_reverse_in && $fell(pins_out.afd_n));
endmodule : eph_asserts
bind eph_top eph_asserts i_eph_asserts (.sys_clk_in(sys_clk_in),
  .nrst_in(nrst_in), .req_in(req_in), .ans_out(ans_out),
  .filter_en_in(filter_en_in), .ecp_reverse_in(ecp_reverse_in),
  .busy_in(busy_in), .ack_n_in(ack_n_in), .pd_in(pd_in),
  .pins_out(pins_out));
`default_nettype wire

// File: eph_periph.sv
/*
  Behavioural 1284 peripheral answering EPP, forward and reverse cycles.
  Assumes the bench resolves the shared data lines from pd_oe.
*/
`timescale 1ns/10ps
`default_nettype none
module eph_periph
  import eph_pkg::*;
(
  input wire logic sys_clk_in,
  input wire eph_pkg::eph_pins_t pins_in,
  input wire logic [eph_pkg::EPH_DW-1:0] pd_in,
  input wire logic rev_in,
  input wire logic go_in,
  input wire logic [3:0] dly_in,
  input wire logic [eph_pkg::EPH_DW-1:0] byte_in,
  output logic busy_out,
  output logic ack_n_out,
  output logic [eph_pkg::EPH_DW-1:0] pd_out,
  output logic [eph_pkg::EPH_DW-1:0] rx_out,
  output int cyc_out
);
  // ---------------------------------------------------------------
  // Handshake
  // ---------------------------------------------------------------
  logic hit;
  assign hit = !(pins_in.stb_n && pins_in.afd_n && pins_in.slin_n);
  initial
  begin
    busy_out = 1'b0;
    ack_n_out = 1'b1;
    pd_out = 8'h5a;
    rx_out = 8'h00;
    cyc_out = 0;
  end
  // Released data inverts so stale bytes never look valid
  always @(posedge sys_clk_in)
  begin
    if (rev_in && go_in)
    begin
      #1 pd_out = byte_in;
      ack_n_out = 1'b0;
      @(posedge sys_clk_in iff !pins_in.afd_n);
      repeat (dly_in) @(posedge sys_clk_in);
      #1 ack_n_out = 1'b1;
      @(posedge sys_clk_in iff pins_in.afd_n);
      #1 pd_out = ~pd_out;
    end
    else if (!rev_in && hit)
    begin
      repeat (dly_in) @(posedge sys_clk_in);
      #1 busy_out = 1'b1;
      pd_out = byte_in;
      rx_out = pd_in;
      cyc_out++;
      @(posedge sys_clk_in iff !hit);
      repeat (dly_in) @(posedge sys_clk_in);
      #1 busy_out = 1'b0;
      pd_out = ~pd_out;
    end
  end
endmodule : eph_periph
`default_nettype wire

// File: tb_top.sv
/*
  Self-checking bench for eph_top with a behavioural peripheral.
  Assumes a 200 MHz clock and inputs driven 1 ns after each edge.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import eph_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  eph_req_t req = '0;
  eph_ans_t ans;
  eph_pins_t pins;
  logic filt = 1'b0, rev = 1'b0, go = 1'b0, busy, ack_n, idle, busy_q, idle_q;
  logic [3:0] dly = 4'h0;
  logic [7:0] byt = 8'h00, ppd, pdw, rx;
  int cyc, rc = 0, rel = 0, err_count = 0, num_checks = 0;
  int r_dw, r_aw, r_ar, r_fw, r_x;
  always #2.5 sys_clk = ~sys_clk;
  assign pdw = pins.pd_oe ? pins.pd : ppd;
  assign idle = pins.stb_n && pins.afd_n && pins.slin_n;
  eph_top i_eph_top (.sys_clk_in(sys_clk), .nrst_in(nrst), .req_in(req),
    .ans_out(ans), .filter_en_in(filt), .ecp_reverse_in(rev),
    .busy_in(busy), .ack_n_in(ack_n), .pd_in(pdw), .pins_out(pins));
  eph_periph i_eph_periph (.sys_clk_in(sys_clk), .pins_in(pins),
    .pd_in(pdw), .rev_in(rev), .go_in(go), .dly_in(dly), .byte_in(byt),
    .busy_out(busy), .ack_n_out(ack_n), .pd_out(ppd), .rx_out(rx),
    .cyc_out(cyc));
  // Cycles from busy rising to the strobe release
  always @(posedge sys_clk)
  begin
    busy_q <= busy;
    idle_q <= idle;
    rc <= (busy && !busy_q) ? 1 : rc + 1;
    if (idle && !idle_q && busy)
      rel <= rc;
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk8
  task automatic chki(input string n, input int e, input int g);
    chk8(n, e[7:0], g[7:0]);
  endtask : chki
  task automatic issue(input eph_req_kind_t k, input logic [7:0] w,
                       output logic dn, output int lat);
    lat = 0;
    @(posedge sys_clk);
    #1 req = '{1'b1, k, w};
    @(posedge sys_clk);
    #1 req.valid = 1'b0;
    while (ans.done !== 1'b1 && ans.retry !== 1'b1 && lat < 40)
    begin
      @(posedge sys_clk);
      #1 lat++;
    end
    dn = ans.done;
  endtask : issue
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_epp(input eph_req_kind_t k, input logic [3:0] d,
                       input logic f, output int r);
    logic dn;
    int lat, n0, i;
    filt = f;
    dly = d;
    byt = 8'h3c + 8'(k);
    n0 = cyc;
    issue(k, 8'ha5, dn, lat);
    chk8("first done", {7'h0, d < 4'h8}, {7'h0, dn});
    if (d >= 4'h8) chki("retry cycle", 16, lat);
    for (i = 0; i < 30 && dn !== 1'b1; i++) issue(k, 8'ha5, dn, lat);
    chk8("repeat done", 8'h01, {7'h0, dn});
    chki("pin cycles", n0 + 1, cyc);
    chk8("data drive", {7'h0, !k[0]}, {7'h0, pins.pd_oe});
    if (!k[0]) chk8("written byte", 8'ha5, rx);
    if (k[0]) chk8("read byte", byt, ans.rdata);
    r = rel;
    $display("test epp kind %0d delay %0d ended", k, d);
  endtask : t_epp
  task automatic t_fwd;
    logic dn;
    int lat, n0, j;
    filt = 1'b0;
    dly = 4'h4;
    n0 = cyc;
    issue(EPH_REQ_FIFO_WR, 8'h11, dn, lat);
    chki("fifo write answer", 0, lat);
    chk8("fifo write done", 8'h01, {7'h0, dn});
    issue(EPH_REQ_FIFO_WR, 8'h22, dn, lat);
    chki("second write answer", 0, lat);
    for (j = 0; j < 100 && cyc < n0 + 1; j++) @(posedge sys_clk);
    chk8("first byte", 8'h11, rx);
    for (j = 0; j < 100 && cyc < n0 + 2; j++) @(posedge sys_clk);
    chk8("second byte", 8'h22, rx);
    // Let the peripheral finish before the mode changes
    for (j = 0; j < 100 && (busy || !pins.stb_n); j++) @(posedge sys_clk);
    #1;
    $display("test forward ended");
  endtask : t_fwd
  task automatic t_rev;
    logic dn;
    int lat, j, i;
    rev = 1'b1;
    dly = 4'h2;
    issue(EPH_REQ_FIFO_RD, 8'h00, dn, lat);
    chk8("empty read done", 8'h00, {7'h0, dn});
    chk8("afd idle", 8'h01, {7'h0, pins.afd_n});
    for (j = 0; j < 2; j++)
    begin
      byt = 8'h81 + 8'(j);
      @(posedge sys_clk);
      #1 go = 1'b1;
      @(posedge sys_clk);
      #1 go = 1'b0;
      for (i = 0; i < 60 && !(ack_n && pins.afd_n && i > 8); i++)
        @(posedge sys_clk);
      issue(EPH_REQ_FIFO_RD, 8'h00, dn, lat);
      chki("fifo read answer", 0, lat);
      chk8("reverse byte", byt, ans.rdata);
    end
    rev = 1'b0;
    $display("test reverse ended");
  endtask : t_rev
  initial
  begin
    #150000;
    err_count++;
    tally_and_finish();
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    chk8("strobes in reset", 8'h07, {5'h0, pins.stb_n, pins.afd_n,
      pins.slin_n});
    #1 nrst = 1'b1;
    t_epp(EPH_REQ_EPP_DATA_WR, 4'hc, 1'b0, r_dw);
    t_epp(EPH_REQ_EPP_ADDR_WR, 4'hc, 1'b0, r_aw);
    t_epp(EPH_REQ_EPP_DATA_RD, 4'hc, 1'b0, r_x);
    t_epp(EPH_REQ_EPP_ADDR_RD, 4'hc, 1'b0, r_ar);
    t_epp(EPH_REQ_EPP_DATA_RD, 4'h0, 1'b0, r_x);
    t_epp(EPH_REQ_EPP_ADDR_WR, 4'hc, 1'b1, r_fw);
    chki("addr write release", r_dw + 1, r_aw);
    chki("addr read release", r_dw, r_ar);
    chki("filtered release", r_aw + 2, r_fw);
    t_fwd();
    t_rev();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
